//--- verilog/ctrp_pkg.sv
`default_nettype none
package ctrp_pkg;

  // Register indices and byte addresses (index times four)
  localparam int unsigned APB_AW       = 8;
  localparam logic [7:0]  REG_IDX_DATA = 8'h1c;
  localparam logic [7:0]  REG_IDX_CMD  = 8'h1e;
  localparam logic [7:0]  ADDR_DATA    = {REG_IDX_DATA[5:0], 2'b00};
  localparam logic [7:0]  ADDR_CMD     = {REG_IDX_CMD[5:0], 2'b00};

  // Command byte fields
  localparam int unsigned CMD_SEL_LO   = 6;
  localparam int unsigned CMD_RW_LO    = 4;
  localparam int unsigned CMD_MODE_LO  = 1;
  localparam int unsigned CMD_BCD      = 0;
  localparam int unsigned RB_COUNT_N   = 5;
  localparam int unsigned RB_STATUS_N  = 4;
  localparam int unsigned RB_TIMEBASE  = 3;
  localparam int unsigned RB_ZERO      = 0;

  // Target select codes
  localparam logic [1:0]  SEL_TIMEBASE = 2'h2;
  localparam logic [1:0]  SEL_RDBACK   = 2'h3;

  // Byte access codes
  localparam logic [1:0]  RW_LATCH     = 2'h0;
  localparam logic [1:0]  RW_LSB       = 2'h1;
  localparam logic [1:0]  RW_MSB       = 2'h2;
  localparam logic [1:0]  RW_LSB_MSB   = 2'h3;

  // Counting modes
  localparam logic [2:0]  MODE_TC      = 3'h0;
  localparam logic [2:0]  MODE_ONESHOT = 3'h1;
  localparam logic [2:0]  MODE_RATE    = 3'h2;
  localparam logic [2:0]  MODE_SQUARE  = 3'h3;
  localparam logic [2:0]  MODE_SWSTRB  = 3'h4;
  localparam logic [2:0]  MODE_HWSTRB  = 3'h5;

  // Reset values
  localparam logic [1:0]  RW_RST       = RW_LSB_MSB;
  localparam logic [2:0]  MODE_RST     = MODE_TC;
  localparam logic        BCD_RST      = 1'b0;
  localparam logic        NULL_RST     = 1'b1;

endpackage
`default_nettype wire

//--- verilog/ctrp_cnt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ctrp_cnt_if;
  logic        cfg_strobe;
  logic [2:0]  mode;
  logic        bcd;
  logic        load_req;
  logic [15:0] load_val;
  logic        load_done;
  logic [15:0] count;
  logic        out_level;

  modport ctl (output cfg_strobe, mode, bcd, load_req, load_val,
               input  load_done, count, out_level);
  modport cnt (input  cfg_strobe, mode, bcd, load_req, load_val,
               output load_done, count, out_level);
endinterface
`default_nettype wire

//--- verilog/ctrp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ctrp_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Pin levels
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1       <= 1'b0;
          s2       <= 1'b0;
          s3       <= 1'b0;
          level[g] <= 1'b0;
        end else begin
          s1 <= pin[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            level[g] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule // ctrp_sync
`default_nettype wire

//--- verilog/ctrp_core.sv
`timescale 1ns/10ps
`default_nettype none
module ctrp_core
  import ctrp_pkg::*;
(
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Filtered pin levels
  input  wire logic   clk_lvl,
  input  wire logic   gate_lvl,
  // Control side
  ctrp_cnt_if.cnt     bus
);
  logic        clk_d;
  logic        gate_d;
  logic        load_pend;
  logic [15:0] pend_val;
  logic [15:0] init;
  logic [15:0] cnt;
  logic        armed;
  logic        trig_pend;
  logic        out;
  logic        done;
  logic [2:0]  mode_eff;
  logic        hw;
  logic        cnt_edge;
  logic        take;
  logic        run;

  function automatic logic [15:0] ctrp_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        b;
    r = v;
    b = 1'b1;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (b) begin
          if (r[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = 4'h9;
          end else begin
            r[4*i +: 4] = r[4*i +: 4] - 4'h1;
            b = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // Reserved codes fold onto the periodic modes
  always_comb begin
    mode_eff = bus.mode;
    if (bus.mode[2:1] == 2'b11) begin
      mode_eff = {1'b0, bus.mode[1:0]};
    end
  end

  assign hw       = (mode_eff == MODE_ONESHOT) || (mode_eff == MODE_HWSTRB);
  assign cnt_edge = clk_lvl & ~clk_d;
  assign take     = cnt_edge & load_pend & ~bus.cfg_strobe & ~bus.load_req;
  assign run      = armed & (hw | gate_lvl);

  // Edge history and load handoff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_d     <= 1'b0;
      gate_d    <= 1'b0;
      load_pend <= 1'b0;
      pend_val  <= 16'h0000;
      init      <= 16'h0000;
      done      <= 1'b0;
      trig_pend <= 1'b0;
    end else begin
      clk_d  <= clk_lvl;
      gate_d <= gate_lvl;
      done   <= take;
      if (take) begin
        init <= pend_val;
      end
      if (bus.load_req) begin
        load_pend <= 1'b1;
        pend_val  <= bus.load_val;
      end else if (take || bus.cfg_strobe) begin
        load_pend <= 1'b0;
      end
      if (hw && gate_lvl && !gate_d) begin
        trig_pend <= 1'b1;
      end else if (bus.cfg_strobe || (cnt_edge && !load_pend)) begin
        trig_pend <= 1'b0;
      end
    end
  end

  // Counting element and output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt   <= 16'h0000;
      armed <= 1'b0;
      out   <= 1'b1;
    end else if (bus.cfg_strobe) begin
      armed <= 1'b0;
      out   <= (bus.mode != MODE_TC);
    end else if (take && !hw) begin
      cnt   <= pend_val;
      armed <= 1'b1;
      if (mode_eff == MODE_TC) begin
        out <= 1'b0;
      end
    end else if (cnt_edge && trig_pend && !load_pend) begin
      cnt   <= init;
      armed <= 1'b1;
      out   <= (mode_eff == MODE_HWSTRB);
    end else if (cnt_edge && run) begin
      case (mode_eff)
        MODE_TC, MODE_ONESHOT: begin
          cnt <= ctrp_dec(cnt, bus.bcd);
          if (cnt == 16'h0001) begin
            out   <= 1'b1;
            armed <= (mode_eff == MODE_TC);
          end
        end
        MODE_RATE: begin
          cnt <= (cnt == 16'h0001) ? init : ctrp_dec(cnt, bus.bcd);
          out <= (cnt != 16'h0002);
        end
        MODE_SQUARE: begin
          if ((cnt == 16'h0001) || (cnt == 16'h0002)) begin
            cnt <= init;
            out <= ~out;
          end else begin
            cnt <= ctrp_dec(ctrp_dec(cnt, bus.bcd), bus.bcd);
          end
        end
        MODE_SWSTRB, MODE_HWSTRB: begin
          if (!out) begin
            out   <= 1'b1;
            armed <= 1'b0;
          end else begin
            cnt <= ctrp_dec(cnt, bus.bcd);
            out <= (cnt != 16'h0001);
          end
        end
        default: begin
          cnt <= cnt;
        end
      endcase
    end
  end

  assign bus.count     = cnt;
  assign bus.out_level = out;
  assign bus.load_done = done;
endmodule // ctrp_core
`default_nettype wire

//--- verilog/ctrp_top.sv
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - A data port write loads the start count per the selected byte order.
// - Data reads give the live count, or latched data when a latch is pending.
// - Latched count or status stays frozen until read out or the counter is reconfigured.
// - While unread, further count or status latches for the counter are ignored.
// - A latched 16-bit count reads low byte first, then high byte.
// - With status and count latched, status reads first, then the count bytes.
// - Command register is write-only; a valid write for counter 3 configures or latches it, others are ignored.
// - Command bits 7-6 select counter 1, 2, 3, or a read-back command.
// - Bits 5-4 give count latch, low only, high only, or low then high.
// - Count latch captures the current count for the next read.
// - Bits 3-1 set one of six counting modes.
// - Bit 0 set counts in BCD, clear counts in 16-bit binary.
// - Read-back low bit 5 latches counts, low bit 4 statuses; bit 0 is zero.
// - Status byte holds output level, unloaded flag, access, mode and BCD.
module ctrp_top
  import ctrp_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Counter pins
  input  wire logic              count_clk_pin,
  input  wire logic              gate_pin,
  output logic                   timer_out
);
  ctrp_cnt_if cnt_bus ();

  logic [1:0]  pin_lvl;
  logic [1:0]  cfg_rw;
  logic [2:0]  cfg_mode;
  logic        cfg_bcd;
  logic        cfg_strobe;
  logic        wr_msb;
  logic        rd_msb;
  logic [7:0]  lsb_hold;
  logic        null_flag;
  logic        load_req;
  logic [15:0] load_val;
  logic        cnt_lat;
  logic [15:0] cnt_lat_val;
  logic        st_lat;
  logic [7:0]  st_lat_val;
  logic [7:0]  cmd;
  logic        acc;
  logic        setup;
  logic        hit_data;
  logic        hit_cmd;
  logic        wr_data;
  logic        wr_cmd;
  logic        rd_data;
  logic        rb_ok;
  logic        cmd_cfg;
  logic        cmd_clatch;
  logic        cmd_slatch;
  logic [7:0]  status_now;
  logic [15:0] src;
  logic [7:0]  rd_byte;

  ctrp_sync #(
    .WIDTH (2)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({gate_pin, count_clk_pin}),
    .level   (pin_lvl)
  );

  ctrp_core u_core (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_lvl  (pin_lvl[0]),
    .gate_lvl (pin_lvl[1]),
    .bus      (cnt_bus)
  );

  assign cnt_bus.cfg_strobe = cfg_strobe;
  assign cnt_bus.mode       = cfg_mode;
  assign cnt_bus.bcd        = cfg_bcd;
  assign cnt_bus.load_req   = load_req;
  assign cnt_bus.load_val   = load_val;
  assign timer_out          = cnt_bus.out_level;

  // Bus decode
  assign cmd      = pwdata[7:0];
  assign setup    = psel & penable & ~pready;
  assign acc      = psel & penable & pready;
  assign hit_data = (paddr == ADDR_DATA);
  assign hit_cmd  = (paddr == ADDR_CMD);
  assign wr_data  = acc & pwrite & hit_data & pstrb[0];
  assign wr_cmd   = acc & pwrite & hit_cmd & pstrb[0];
  assign rd_data  = acc & ~pwrite & hit_data;

  // Command decode
  assign rb_ok      = wr_cmd && (cmd[CMD_SEL_LO +: 2] == SEL_RDBACK) && !cmd[RB_ZERO] && cmd[RB_TIMEBASE];
  assign cmd_cfg    = wr_cmd && (cmd[CMD_SEL_LO +: 2] == SEL_TIMEBASE) && (cmd[CMD_RW_LO +: 2] != RW_LATCH);
  assign cmd_clatch = (wr_cmd && (cmd[CMD_SEL_LO +: 2] == SEL_TIMEBASE) && (cmd[CMD_RW_LO +: 2] == RW_LATCH))
                      || (rb_ok && !cmd[RB_COUNT_N]);
  assign cmd_slatch = rb_ok && !cmd[RB_STATUS_N];

  assign status_now = {cnt_bus.out_level, null_flag, cfg_rw, cfg_mode, cfg_bcd};

  // Read byte selection
  always_comb begin
    src     = cnt_lat ? cnt_lat_val : cnt_bus.count;
    rd_byte = src[7:0];
    if (st_lat) begin
      rd_byte = st_lat_val;
    end else begin
      case (cfg_rw)
        RW_MSB:     rd_byte = src[15:8];
        RW_LSB_MSB: rd_byte = rd_msb ? src[15:8] : src[7:0];
        default:    rd_byte = src[7:0];
      endcase
    end
  end

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= {24'h00_0000, (hit_data && !pwrite) ? rd_byte : 8'h00};
        pslverr <= !(hit_data || hit_cmd);
      end else if (!acc) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Counter configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_rw     <= RW_RST;
      cfg_mode   <= MODE_RST;
      cfg_bcd    <= BCD_RST;
      cfg_strobe <= 1'b0;
    end else begin
      cfg_strobe <= cmd_cfg;
      if (cmd_cfg) begin
        cfg_rw   <= cmd[CMD_RW_LO +: 2];
        cfg_mode <= cmd[CMD_MODE_LO +: 3];
        cfg_bcd  <= cmd[CMD_BCD];
      end
    end
  end

  // Start value assembly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_msb   <= 1'b0;
      lsb_hold <= 8'h00;
      load_req <= 1'b0;
      load_val <= 16'h0000;
    end else begin
      load_req <= 1'b0;
      if (cmd_cfg) begin
        wr_msb <= 1'b0;
      end else if (wr_data) begin
        case (cfg_rw)
          RW_LSB: begin
            load_val <= {8'h00, cmd};
            load_req <= 1'b1;
          end
          RW_MSB: begin
            load_val <= {cmd, 8'h00};
            load_req <= 1'b1;
          end
          RW_LSB_MSB: begin
            if (!wr_msb) begin
              lsb_hold <= cmd;
              wr_msb   <= 1'b1;
            end else begin
              load_val <= {cmd, lsb_hold};
              load_req <= 1'b1;
              wr_msb   <= 1'b0;
            end
          end
          default: begin
            wr_msb <= wr_msb;
          end
        endcase
      end
    end
  end

  // Unloaded-count flag, set wins over the load acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      null_flag <= NULL_RST;
    end else if (cmd_cfg || load_req) begin
      null_flag <= 1'b1;
    end else if (cnt_bus.load_done && !cfg_strobe) begin
      null_flag <= 1'b0;
    end
  end

  // Status latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_lat     <= 1'b0;
      st_lat_val <= 8'h00;
    end else if (cmd_cfg) begin
      st_lat <= 1'b0;
    end else if (cmd_slatch && !st_lat) begin
      st_lat     <= 1'b1;
      st_lat_val <= status_now;
    end else if (rd_data && st_lat) begin
      st_lat <= 1'b0;
    end
  end

  // Count latch and read byte order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lat     <= 1'b0;
      cnt_lat_val <= 16'h0000;
      rd_msb      <= 1'b0;
    end else if (cmd_cfg) begin
      cnt_lat <= 1'b0;
      rd_msb  <= 1'b0;
    end else if (cmd_clatch && !cnt_lat) begin
      cnt_lat     <= 1'b1;
      cnt_lat_val <= cnt_bus.count;
    end else if (rd_data && !st_lat) begin
      if (cfg_rw == RW_LSB_MSB) begin
        rd_msb <= ~rd_msb;
        if (rd_msb) begin
          cnt_lat <= 1'b0;
        end
      end else begin
        cnt_lat <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read_setup;
    setup && !pwrite && hit_data;
  endsequence

  sequence s_hi_write;
    wr_data && (cfg_rw == RW_LSB_MSB) && wr_msb;
  endsequence

  sequence s_lat_lo_read;
    rd_data && cnt_lat && !st_lat && (cfg_rw == RW_LSB_MSB) && !rd_msb;
  endsequence

  property p_load_lsb;
    wr_data && (cfg_rw == RW_LSB) |=> load_req && (load_val == {8'h00, $past(pwdata[7:0])}) ##1 !load_req;
  endproperty
  a_load_lsb: assert property (p_load_lsb) else $error("low byte load wrong");

  property p_load_pair;
    s_hi_write |=> load_req && (load_val == {$past(pwdata[7:0]), $past(lsb_hold)}) && !wr_msb;
  endproperty
  a_load_pair: assert property (p_load_pair) else $error("two byte load wrong");

  property p_live_read;
    s_read_setup and (!st_lat && !cnt_lat && (cfg_rw == RW_LSB))
      |=> pready && (prdata[7:0] == $past(cnt_bus.count[7:0]));
  endproperty
  a_live_read: assert property (p_live_read) else $error("live read wrong");

  property p_lat_hold;
    cnt_lat && !rd_data && !cmd_cfg |=> cnt_lat && $stable(cnt_lat_val);
  endproperty
  a_lat_hold: assert property (p_lat_hold) else $error("latched count changed");

  property p_first_only;
    st_lat && cmd_slatch |=> st_lat && $stable(st_lat_val);
  endproperty
  a_first_only: assert property (p_first_only) else $error("second status latch honoured");

  property p_lat_order;
    s_lat_lo_read |=> rd_msb && cnt_lat && $stable(cnt_lat_val);
  endproperty
  a_lat_order: assert property (p_lat_order) else $error("latched byte order wrong");

  property p_status_first;
    s_read_setup and (st_lat && cnt_lat) |=> (prdata[7:0] == $past(st_lat_val)) ##1 (!st_lat && cnt_lat);
  endproperty
  a_status_first: assert property (p_status_first) else $error("status not read first");

  property p_clatch;
    cmd_clatch && !cnt_lat && !cmd_cfg |=> cnt_lat && (cnt_lat_val == $past(cnt_bus.count));
  endproperty
  a_clatch: assert property (p_clatch) else $error("count latch missed");

  property p_cfg;
    cmd_cfg |=> (cfg_mode == $past(pwdata[3:1])) && (cfg_bcd == $past(pwdata[0])) && cfg_strobe;
  endproperty
  a_cfg: assert property (p_cfg) else $error("mode or format not stored");

  property p_rb_zero;
    wr_cmd && (cmd[CMD_SEL_LO +: 2] == SEL_RDBACK) && cmd[RB_ZERO]
      |=> $stable(st_lat) && $stable(cnt_lat);
  endproperty
  a_rb_zero: assert property (p_rb_zero) else $error("bad read-back acted");

  property p_status_fmt;
    cmd_slatch && !st_lat && !cmd_cfg
      |=> st_lat && (st_lat_val[5:0] == {cfg_rw, cfg_mode, cfg_bcd}) && (st_lat_val[6] == $past(null_flag));
  endproperty
  a_status_fmt: assert property (p_status_fmt) else $error("status byte wrong");

  property p_apb_wait;
    setup |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("answer timing wrong");

endmodule // ctrp_top
`default_nettype wire

//--- verification/ctrp_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ctrp_tb;
  import ctrp_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        count_clk_pin;
  logic        gate_pin;
  logic        timer_out;
  int          n_errors;
  int          n_compared;
  int          seed;
  logic [31:0] rdv;
  logic        err;
  logic [15:0] val;
  logic [7:0]  b;
  logic [1:0]  rw;
  logic [2:0]  md;
  logic        bcd;

  ctrp_top ctrp_top_i (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .pstrb         (pstrb),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .count_clk_pin (count_clk_pin),
    .gate_pin      (gate_pin),
    .timer_out     (timer_out)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic final_report();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Status byte as the counter should report it
  function automatic logic [7:0] stat(input logic o, input logic nl, input logic [1:0] a,
                                      input logic [2:0] m, input logic d);
    return {o, nl, a, m, d};
  endfunction

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                     input logic [3:0] strb);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {24'h0, wd};
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      final_report();
    end else begin
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] d);
    apb(1'b1, addr, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] addr);
    apb(1'b0, addr, 8'h00, 4'h0);
  endtask

  // Counter clock pulses, long enough for the pin synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      count_clk_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      count_clk_pin <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask

  task automatic rd_status(input logic [7:0] exp, input logic [7:0] mask);
    wr(ADDR_CMD, 8'he8);
    rd(ADDR_DATA);
    chk("status", rdv & {24'h0, mask}, {24'h0, exp & mask});
  endtask

  initial begin
    seed = 7;
    n_errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    count_clk_pin = 1'b0;
    gate_pin = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_status(stat(1'b1, 1'b1, RW_RST, MODE_RST, BCD_RST), 8'hff);
    rd(8'h00);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rdv, 32'h0);
    wr(8'h04, 8'h55);
    chk("unmapped_wr_err", {31'h0, err}, 32'h1);
    rd(ADDR_CMD);
    chk("cmd_read", rdv, 32'h0);
    chk("cmd_read_err", {31'h0, err}, 32'h0);
    // Random configurations echoed through the status byte
    for (int i = 0; i < 10; i++) begin
      rw  = 2'($unsigned($random(seed)) % 3 + 1);
      md  = 3'($unsigned($random(seed)) % 6);
      bcd = 1'($random(seed));
      if (i < 6) begin
        md = 3'(i);
      end
      wr(ADDR_CMD, {SEL_TIMEBASE, rw, md, bcd});
      rd_status({2'b00, rw, md, bcd}, 8'h3f);
    end
    // Foreign counter and masked write leave counter 3 alone
    wr(ADDR_CMD, {SEL_TIMEBASE, RW_MSB, MODE_TC, 1'b0});
    wr(ADDR_CMD, 8'h12);
    rd_status({2'b00, RW_MSB, MODE_TC, 1'b0}, 8'h3f);
    apb(1'b1, ADDR_CMD, 8'hb6, 4'h0);
    rd_status({2'b00, RW_MSB, MODE_TC, 1'b0}, 8'h3f);
    // Two-byte load in mode 0, binary
    val = 16'($random(seed));
    if (val < 16'h0010) begin
      val = val + 16'h0010;
    end
    wr(ADDR_CMD, {SEL_TIMEBASE, RW_LSB_MSB, MODE_TC, 1'b0});
    wr(ADDR_DATA, val[7:0]);
    wr(ADDR_DATA, val[15:8]);
    rd_status({1'b0, 1'b1, RW_LSB_MSB, MODE_TC, 1'b0}, 8'h7f);
    pulse(1);
    rd_status(stat(1'b0, 1'b0, RW_LSB_MSB, MODE_TC, 1'b0), 8'hff);
    chk("timer_out", {31'h0, timer_out}, 32'h0);
    rd(ADDR_DATA);
    chk("live_lsb", rdv, {24'h0, val[7:0]});
    rd(ADDR_DATA);
    chk("live_msb", rdv, {24'h0, val[15:8]});
    // Latch, keep counting, second latch ignored
    wr(ADDR_CMD, {SEL_TIMEBASE, RW_LATCH, 4'h0});
    pulse(3);
    wr(ADDR_CMD, {SEL_TIMEBASE, RW_LATCH, 4'h0});
    wr(ADDR_CMD, 8'hd8);
    rd(ADDR_DATA);
    chk("latch_lsb", rdv, {24'h0, val[7:0]});
    rd(ADDR_DATA);
    chk("latch_msb", rdv, {24'h0, val[15:8]});
    // Count latched before status; status still reads first
    val = val - 16'd3;
    wr(ADDR_CMD, {SEL_TIMEBASE, RW_LATCH, 4'h0});
    wr(ADDR_CMD, 8'he8);
    wr(ADDR_CMD, 8'he8);
    rd(ADDR_DATA);
    chk("both_status", rdv, {24'h0, stat(1'b0, 1'b0, RW_LSB_MSB, MODE_TC, 1'b0)});
    rd(ADDR_DATA);
    chk("both_lsb", rdv, {24'h0, val[7:0]});
    rd(ADDR_DATA);
    chk("both_msb", rdv, {24'h0, val[15:8]});
    // Read-back with bit 0 set, or without counter 3, is ignored
    wr(ADDR_CMD, 8'hc9);
    wr(ADDR_CMD, 8'hc6);
    rd(ADDR_DATA);
    chk("rb_bad_lsb", rdv, {24'h0, val[7:0]});
    rd(ADDR_DATA);
    chk("rb_bad_msb", rdv, {24'h0, val[15:8]});
    // Read-back of counts and statuses in one command
    wr(ADDR_CMD, 8'hc8);
    rd(ADDR_DATA);
    chk("rb_status", rdv, {24'h0, stat(1'b0, 1'b0, RW_LSB_MSB, MODE_TC, 1'b0)});
    rd(ADDR_DATA);
    chk("rb_lsb", rdv, {24'h0, val[7:0]});
    rd(ADDR_DATA);
    chk("rb_msb", rdv, {24'h0, val[15:8]});
    // Single-byte access codes
    b = 8'($random(seed)) | 8'h10;
    wr(ADDR_CMD, {SEL_TIMEBASE, RW_LSB, MODE_TC, 1'b0});
    wr(ADDR_DATA, b);
    pulse(1);
    wr(ADDR_CMD, {SEL_TIMEBASE, RW_LATCH, 4'h0});
    rd(ADDR_DATA);
    chk("lsb_only_latch", rdv, {24'h0, b});
    rd(ADDR_DATA);
    chk("lsb_only_live", rdv, {24'h0, b});
    wr(ADDR_CMD, {SEL_TIMEBASE, RW_MSB, MODE_TC, 1'b0});
    wr(ADDR_DATA, ~b);
    pulse(1);
    rd(ADDR_DATA);
    chk("msb_only_live", rdv, {24'h0, ~b});
    final_report();
  end
endmodule // ctrp_tb
`default_nettype wire
